//--- rwp_pkg.sv
package rwp_pkg;

  // Register indices on the plain register port
  localparam logic [1:0] ADDR_WD_STATUS = 2'h0;
  localparam logic [1:0] ADDR_SUPV_INHIBIT = 2'h1;
  localparam logic [1:0] ADDR_DIVIDER = 2'h2;
  localparam logic [1:0] ADDR_RESET_SEL = 2'h3;

  // watchdog_status_ctrl fields
  localparam int WD_CLEAR_BIT = 3;
  localparam int SLEEP_UNLOCK_BIT = 2;
  // supervisor_inhibit_ctrl fields
  localparam int REF_SEL_BIT = 3;
  localparam int OSC_INHIBIT_BIT = 1;
  localparam int WD_INHIBIT_BIT = 0;
  // divider_ctrl fields
  localparam int PWM_EN_BIT = 3;
  localparam int DIV_CLEAR_BIT = 2;
  localparam int TICK_SEL_BIT = 1;
  localparam int DEB_SEL_BIT = 0;

  localparam logic [3:0] REG_RESET = 4'h0;
  localparam logic [7:0] SEL_RESET = 8'h00;

  // Divider: 15 stages, tap index k is clock divided by 2^(k+1)
  localparam int DIV_STAGES = 15;
  localparam logic [14:0] DIV_POWERON = 15'h0001;
  localparam int TAP_8192HZ = 1;
  localparam int TAP_1024HZ = 4;
  localparam int TAP_128HZ = 7;
  localparam int TAP_32HZ = 9;
  localparam int TAP_8HZ = 11;
  localparam int TAP_2HZ = 13;
  localparam int TAP_1HZ = 14;
  localparam logic [14:0] DIV_CLEAR_VALUE = 15'h4000;

  // Qualification time for the input reset, counted on the 1024 Hz tap
  localparam int QUAL_MS = 16;
  localparam int QUAL_TAP_HZ = 1024;
  localparam int QUAL_TICKS = (QUAL_MS * QUAL_TAP_HZ + 999) / 1000;

  // Term selector codes
  typedef enum logic [1:0] {
    TERM_LOW = 2'b00,
    TERM_PIN = 2'b01,
    TERM_INV = 2'b10,
    TERM_HIGH = 2'b11
  } term_sel_e;

  typedef struct packed {
    logic [1:0] addr;
    logic [3:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic selectableTickIrq;
    logic oneHertzIrq;
  } tick_irq_s;

endpackage

//--- input_term_sel.sv
`timescale 1ns/100ps
module input_term_sel (
  input wire logic [1:0] sel,
  input wire logic pin,
  output logic term
);

  always_comb begin
    case (sel)
      rwp_pkg::TERM_LOW: term = 1'b0;
      rwp_pkg::TERM_PIN: term = pin;
      rwp_pkg::TERM_INV: term = ~pin;
      rwp_pkg::TERM_HIGH: term = 1'b1;
      default: term = 1'b0;
    endcase
  end

endmodule

//--- reset_watchdog_prescaler.sv
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module reset_watchdog_prescaler #(
  parameter bit OR_TYPE = 1'b0,
  parameter bit FAST_DEBOUNCE = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire rwp_pkg::reg_req_s regReq,
  output logic [3:0] regRdata,
  input wire logic [3:0] portAInput,
  input wire logic sleepMode,
  input wire logic standbyMode,
  output logic systemReset,
  output logic watchdogReset,
  output logic inputReset,
  output rwp_pkg::tick_irq_s tickIrq,
  output logic debounceClock,
  output logic sleepUnlock,
  output logic oscSupervisorInhibit,
  output logic converterReferenceSelect,
  output logic counterPulseWidthEnable
);

  logic [3:0] padSync1_r;
  logic [3:0] padSync2_r;
  logic [14:0] div_r;
  logic [14:0] divPrev_r;
  logic [1:0] wdCount_r;
  logic wdInhibit_r;
  logic wdExpired_r;
  logic sleepUnlock_r;
  logic oscInhibit_r;
  logic refSel_r;
  logic pwmEn_r;
  logic tickSel_r;
  logic debounce_clock_select_r;
  logic [7:0] termSel_r;
  logic [4:0] qualCount_r;
  logic qualDone_r;
  logic sleepReset_r;
  logic sleepInputResetEnable_r;
  logic [3:0] rdata_r;
  logic sysReset_r;
  logic tickIrq_r;
  logic hzIrq_r;
  logic [3:0] terms;
  logic combinedResetRequest;
  logic wrStrobe;
  logic rdStrobe;
  logic wdClearWrite;
  logic divClearWrite;
  logic hzRise;
  logic qualTapRise;
  logic tickSrc;
  logic tickSrcPrev;

  assign wrStrobe = regReq.wr & clkEn;
  assign rdStrobe = regReq.rd & clkEn;
  assign wdClearWrite = wrStrobe && regReq.addr == rwp_pkg::ADDR_WD_STATUS
                        && regReq.wdata[rwp_pkg::WD_CLEAR_BIT];
  assign divClearWrite = wrStrobe && regReq.addr == rwp_pkg::ADDR_DIVIDER
                         && regReq.wdata[rwp_pkg::DIV_CLEAR_BIT];

  // Pins are asynchronous to clk
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      padSync1_r <= 4'h0;
      padSync2_r <= 4'h0;
    end else if (clkEn) begin
      padSync1_r <= portAInput;
      padSync2_r <= padSync1_r;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_term
      input_term_sel u_term (
        .sel(termSel_r[2*gi +: 2]),
        .pin(padSync2_r[gi]),
        .term(terms[gi])
      );
    end
  endgenerate

  // Build option picks the combination type
  assign combinedResetRequest = OR_TYPE ? |terms : &terms;

  // Divider: power-on value, software clear of stages 0 to 13 with the top stage set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= rwp_pkg::DIV_POWERON;
    end else if (clkEn) begin
      if (divClearWrite) begin
        div_r <= rwp_pkg::DIV_CLEAR_VALUE;
      end else begin
        div_r <= div_r + 15'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divPrev_r <= rwp_pkg::DIV_POWERON;
      tickSrcPrev <= 1'b0;
    end else if (clkEn) begin
      divPrev_r <= div_r;
      tickSrcPrev <= tickSrc;
    end
  end

  // Taps are the divider bits counted from the LSB; tap k toggles every 2^k cycles
  assign hzRise = div_r[rwp_pkg::TAP_1HZ] & ~divPrev_r[rwp_pkg::TAP_1HZ];
  assign qualTapRise = div_r[rwp_pkg::TAP_1024HZ]
                       & ~divPrev_r[rwp_pkg::TAP_1024HZ];
  assign tickSrc = tickSel_r ? div_r[rwp_pkg::TAP_32HZ]
                             : div_r[rwp_pkg::TAP_8HZ];

  // Tick interrupts are one-cycle pulses; the reset value of the taps
  // holds them low, so none fires out of reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tickIrq_r <= 1'b0;
      hzIrq_r <= 1'b0;
    end else if (clkEn) begin
      tickIrq_r <= tickSrc & ~tickSrcPrev;
      hzIrq_r <= hzRise;
    end else begin
      tickIrq_r <= 1'b0;
      hzIrq_r <= 1'b0;
    end
  end

  assign tickIrq.selectableTickIrq = tickIrq_r;
  assign tickIrq.oneHertzIrq = hzIrq_r;

  always_comb begin
    if (!debounce_clock_select_r) begin
      debounceClock = div_r[rwp_pkg::TAP_128HZ];
    end else if (FAST_DEBOUNCE) begin
      debounceClock = div_r[rwp_pkg::TAP_8192HZ];
    end else begin
      debounceClock = div_r[rwp_pkg::TAP_1024HZ];
    end
  end

  // Qualification: counts 1024 Hz edges while the request holds
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      qualCount_r <= 5'h00;
      qualDone_r <= 1'b0;
    end else if (clkEn) begin
      if (!combinedResetRequest || sysReset_r || sleepMode) begin
        qualCount_r <= 5'h00;
        qualDone_r <= 1'b0;
      end else if (qualTapRise) begin
        if (qualCount_r == 5'(rwp_pkg::QUAL_TICKS)) begin
          qualDone_r <= 1'b1;
        end else begin
          qualCount_r <= qualCount_r + 5'h01;
        end
      end
    end
  end

  // Sleep path bypasses qualification entirely
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleepReset_r <= 1'b0;
    end else if (clkEn) begin
      sleepReset_r <= sleepMode & sleepInputResetEnable_r
                      & combinedResetRequest;
    end
  end

  assign inputReset = qualDone_r | sleepReset_r;

  // Watchdog: counts through standby as well, since only clkEn freezes it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdCount_r <= 2'b00;
      wdExpired_r <= 1'b0;
    end else if (clkEn) begin
      if (sysReset_r || wdInhibit_r) begin
        wdCount_r <= 2'b00;
        wdExpired_r <= 1'b0;
      end else if (wdClearWrite) begin
        wdCount_r <= 2'b00;
        wdExpired_r <= 1'b0;
      end else if (hzRise) begin
        if (wdCount_r == 2'b11) begin
          wdExpired_r <= 1'b1;
        end else begin
          wdCount_r <= wdCount_r + 2'b01;
        end
      end
    end
  end

  assign watchdogReset = wdExpired_r;

  // System reset lasts at least two cycles so every state above sees it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sysReset_r <= 1'b0;
    end else if (clkEn) begin
      sysReset_r <= wdExpired_r | inputReset;
    end
  end

  assign systemReset = sysReset_r;

  // Registers; inhibit falls back to enabled on any system reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdInhibit_r <= 1'b0;
      oscInhibit_r <= 1'b0;
      refSel_r <= 1'b0;
    end else if (clkEn) begin
      if (sysReset_r) begin
        wdInhibit_r <= 1'b0;
        oscInhibit_r <= 1'b0;
      end else if (wrStrobe
                   && regReq.addr == rwp_pkg::ADDR_SUPV_INHIBIT) begin
        wdInhibit_r <= regReq.wdata[rwp_pkg::WD_INHIBIT_BIT];
        oscInhibit_r <= regReq.wdata[rwp_pkg::OSC_INHIBIT_BIT];
        refSel_r <= regReq.wdata[rwp_pkg::REF_SEL_BIT];
      end
    end
  end

  // Option-like state survives system reset, only power-on clears it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleepUnlock_r <= 1'b0;
      pwmEn_r <= 1'b0;
      tickSel_r <= 1'b0;
      debounce_clock_select_r <= 1'b0;
      termSel_r <= rwp_pkg::SEL_RESET;
      sleepInputResetEnable_r <= 1'b0;
    end else if (clkEn && wrStrobe) begin
      case (regReq.addr)
        rwp_pkg::ADDR_WD_STATUS: begin
          sleepUnlock_r <= regReq.wdata[rwp_pkg::SLEEP_UNLOCK_BIT];
        end
        rwp_pkg::ADDR_DIVIDER: begin
          pwmEn_r <= regReq.wdata[rwp_pkg::PWM_EN_BIT];
          tickSel_r <= regReq.wdata[rwp_pkg::TICK_SEL_BIT];
          debounce_clock_select_r <= regReq.wdata[rwp_pkg::DEB_SEL_BIT];
        end
        rwp_pkg::ADDR_RESET_SEL: begin
          // Bits 0..3 fill the low nibble, old low nibble shifts up; each write packs two terms
          termSel_r <= {termSel_r[3:0], regReq.wdata};
          sleepInputResetEnable_r <= 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // Read data one cycle after the read strobe; write-one bits read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= rwp_pkg::REG_RESET;
    end else if (clkEn) begin
      if (rdStrobe) begin
        case (regReq.addr)
          rwp_pkg::ADDR_WD_STATUS:
            rdata_r <= {1'b0, sleepUnlock_r, wdCount_r};
          rwp_pkg::ADDR_SUPV_INHIBIT:
            rdata_r <= {refSel_r, 1'b0, oscInhibit_r, wdInhibit_r};
          rwp_pkg::ADDR_DIVIDER:
            rdata_r <= {pwmEn_r, 1'b0, tickSel_r, debounce_clock_select_r};
          rwp_pkg::ADDR_RESET_SEL:
            rdata_r <= termSel_r[3:0];
          default:
            rdata_r <= 4'h0;
        endcase
      end else begin
        rdata_r <= 4'h0;
      end
    end
  end

  assign regRdata = rdata_r;
  assign sleepUnlock = sleepUnlock_r;
  assign oscSupervisorInhibit = oscInhibit_r;
  assign converterReferenceSelect = refSel_r;
  assign counterPulseWidthEnable = pwmEn_r;

  AST_WD_CLEAR_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && wdClearWrite |=> wdCount_r == 2'b00)
    else $error("watchdog count not zero after clear");

  AST_WD_INHIBIT_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    wdInhibit_r && $past(wdInhibit_r) |-> wdCount_r == 2'b00)
    else $error("inhibited watchdog count not zero");

  AST_WD_STEP: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && hzRise && !wdInhibit_r && !sysReset_r && !wdClearWrite
    && wdCount_r != 2'b11 |=> wdCount_r == $past(wdCount_r) + 2'b01)
    else $error("watchdog count did not step on 1 Hz edge");

  AST_WD_EXPIRE: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && hzRise && wdCount_r == 2'b11 && !wdInhibit_r && !sysReset_r
    && !wdClearWrite |=> watchdogReset)
    else $error("watchdog did not expire from state 11");

  AST_SYSRST_REENABLE: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && sysReset_r |=> !wdInhibit_r)
    else $error("watchdog inhibit survived system reset");

  AST_DIV_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && divClearWrite |=> div_r == rwp_pkg::DIV_CLEAR_VALUE)
    else $error("divider clear value wrong");

  AST_HZ_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && hzRise |=> tickIrq.oneHertzIrq)
    else $error("1 Hz interrupt missing");

  AST_QUAL_DROP: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && !combinedResetRequest |=> qualCount_r == 5'h00 && !qualDone_r)
    else $error("qualification not restarted");

endmodule

//--- port_a_pins.sv
`timescale 1ns/100ps
module port_a_pins (
  input wire logic [3:0] drive,
  input wire logic [3:0] level,
  output logic [3:0] pins
);
  // Released pins fall to the pull-down level, never hold the last value
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pins[i] = drive[i] ? level[i] : 1'b0;
    end
  end
endmodule

//--- reset_watchdog_prescaler_bench.sv
`timescale 1ns/100ps
module reset_watchdog_prescaler_bench;
  typedef struct {
    logic [7:0] sel;
    logic [3:0] pins;
    logic expAnd;
    logic expOr;
  } row_s;
  logic clk;
  logic rst_n;
  logic clkEn;
  rwp_pkg::reg_req_s regReq;
  logic [3:0] regRdata;
  logic [3:0] pinDrive;
  logic [3:0] pinLevel;
  logic [3:0] portAInput;
  logic sleepMode;
  logic standbyMode;
  logic systemReset;
  logic watchdogReset;
  logic inputReset;
  logic inputResetOr;
  rwp_pkg::tick_irq_s tickIrq;
  logic debounceClock;
  logic debounceOr;
  logic sleepUnlock;
  logic oscInh;
  logic refSel;
  logic pwmEn;
  int n_mismatch;
  int checks_done;
  int n;
  logic [3:0] rv;
  logic seenAnd;
  logic seenOr;
  row_s rows [8];

  port_a_pins u_pins (.drive(pinDrive), .level(pinLevel), .pins(portAInput));

  reset_watchdog_prescaler u_dut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
    .regReq(regReq), .regRdata(regRdata), .portAInput(portAInput),
    .sleepMode(sleepMode), .standbyMode(standbyMode),
    .systemReset(systemReset), .watchdogReset(watchdogReset),
    .inputReset(inputReset), .tickIrq(tickIrq),
    .debounceClock(debounceClock), .sleepUnlock(sleepUnlock),
    .oscSupervisorInhibit(oscInh), .converterReferenceSelect(refSel),
    .counterPulseWidthEnable(pwmEn));

  // Second build: OR combination and the fast debounce tap
  reset_watchdog_prescaler #(.OR_TYPE(1'b1), .FAST_DEBOUNCE(1'b1)) u_dutOr (
    .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .regReq(regReq),
    .regRdata(), .portAInput(portAInput), .sleepMode(sleepMode),
    .standbyMode(standbyMode), .systemReset(), .watchdogReset(),
    .inputReset(inputResetOr), .tickIrq(), .debounceClock(debounceOr),
    .sleepUnlock(), .oscSupervisorInhibit(), .converterReferenceSelect(),
    .counterPulseWidthEnable());

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cmpVal(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmpRange(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, got, lo);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [3:0] d);
    @(posedge clk);
    regReq.addr <= a;
    regReq.wdata <= d;
    regReq.wr <= 1'b1;
    @(posedge clk);
    regReq.wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [3:0] d);
    @(posedge clk);
    regReq.addr <= a;
    regReq.rd <= 1'b1;
    @(posedge clk);
    regReq.rd <= 1'b0;
    #1 d = regRdata;
  endtask

  // Upper nibble of the select byte goes first
  task automatic wrSel(input logic [7:0] s);
    wr(rwp_pkg::ADDR_RESET_SEL, s[7:4]);
    wr(rwp_pkg::ADDR_RESET_SEL, s[3:0]);
  endtask

  function automatic logic sigOf(input int which);
    case (which)
      0: return tickIrq.oneHertzIrq;
      1: return tickIrq.selectableTickIrq;
      2: return debounceClock;
      3: return debounceOr;
      default: return inputReset;
    endcase
  endfunction

  // Counts cycles until the next rising edge of the chosen signal
  task automatic waitRise(input int which, input int lim, output int cnt);
    cnt = 0;
    while (sigOf(which) === 1'b1 && cnt <= lim) begin
      @(posedge clk);
      #1 cnt++;
    end
    while (sigOf(which) !== 1'b1 && cnt <= lim) begin
      @(posedge clk);
      #1 cnt++;
    end
    if (cnt > lim) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, cnt, lim);
      final_report();
    end
  endtask

  task automatic period(input int which, input int exp);
    waitRise(which, exp + 40, n);
    waitRise(which, exp + 40, n);
    cmpRange(n, exp, exp);
  endtask

  initial begin
    rows[0] = '{8'hff, 4'h0, 1'b1, 1'b1};
    rows[1] = '{8'h55, 4'hf, 1'b1, 1'b1};
    rows[2] = '{8'h55, 4'he, 1'b0, 1'b1};
    rows[3] = '{8'haa, 4'h0, 1'b1, 1'b1};
    rows[4] = '{8'haa, 4'hf, 1'b0, 1'b0};
    rows[5] = '{8'hfc, 4'hf, 1'b0, 1'b1};
    rows[6] = '{8'h7f, 4'h8, 1'b1, 1'b1};
    rows[7] = '{8'h00, 4'hf, 1'b0, 1'b0};
    n_mismatch = 0;
    checks_done = 0;
    rst_n = 1'b0;
    clkEn = 1'b1;
    regReq = '0;
    pinDrive = 4'h0;
    pinLevel = 4'hf;
    sleepMode = 1'b0;
    standbyMode = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    #1 cmpVal({systemReset, watchdogReset, inputReset}, 4'h0);
    cmpVal({2'b00, tickIrq}, 4'h0);
    for (int a = 0; a < 3; a++) begin
      rd(a[1:0], rv);
      cmpVal(rv, rwp_pkg::REG_RESET);
    end
    standbyMode <= 1'b1;
    waitRise(0, 33000, n);
    cmpRange(n, 16370, 16384);
    rd(rwp_pkg::ADDR_WD_STATUS, rv);
    cmpVal(rv, 4'h1);
    waitRise(0, 33000, n);
    cmpRange(n, 32760, 32768);
    rd(rwp_pkg::ADDR_WD_STATUS, rv);
    cmpVal(rv, 4'h2);
    standbyMode <= 1'b0;
    wr(rwp_pkg::ADDR_WD_STATUS, 4'hc);
    rd(rwp_pkg::ADDR_WD_STATUS, rv);
    cmpVal(rv, 4'h4);
    wr(rwp_pkg::ADDR_SUPV_INHIBIT, 4'hb);
    rd(rwp_pkg::ADDR_SUPV_INHIBIT, rv);
    cmpVal(rv, 4'hb);
    cmpVal({sleepUnlock, oscInh, refSel}, 4'h7);
    wr(rwp_pkg::ADDR_DIVIDER, 4'h4);
    waitRise(0, 33000, n);
    cmpRange(n, 32760, 32780);
    rd(rwp_pkg::ADDR_WD_STATUS, rv);
    cmpVal(rv, 4'h4);
    wr(rwp_pkg::ADDR_DIVIDER, 4'h9);
    rd(rwp_pkg::ADDR_DIVIDER, rv);
    cmpVal({rv[3:1], pwmEn}, 4'h9);
    period(2, 32);
    period(3, 4);
    period(1, 4096);
    wr(rwp_pkg::ADDR_DIVIDER, 4'h2);
    period(1, 1024);
    period(2, 256);
    foreach (rows[i]) begin
      wrSel(rows[i].sel);
      pinDrive <= rows[i].pins;
      // Qualification is 16 ms nominal, 18 edges of the 1024 Hz tap, up to 576 cycles here; the
      // qualified reset is a short pulse, since it clears its own count
      seenAnd = 1'b0;
      seenOr = 1'b0;
      repeat (620) begin
        @(posedge clk);
        #1 seenAnd = seenAnd | inputReset;
        seenOr = seenOr | inputResetOr;
      end
      cmpVal({3'b000, seenAnd}, {3'b000, rows[i].expAnd});
      cmpVal({3'b000, seenOr}, {3'b000, rows[i].expOr});
      wrSel(8'h00);
      repeat (20) @(posedge clk);
      #1 cmpVal({inputReset, inputResetOr}, 4'h0);
    end
    rd(rwp_pkg::ADDR_SUPV_INHIBIT, rv);
    cmpVal(rv, 4'h8);
    wrSel(8'h55);
    pinDrive <= 4'hf;
    repeat (400) @(posedge clk);
    pinDrive <= 4'h0;
    repeat (4) @(posedge clk);
    pinDrive <= 4'hf;
    #1 waitRise(4, 700, n);
    cmpRange(n, 512, 600);
    pinDrive <= 4'h0;
    wrSel(8'h00);
    repeat (20) @(posedge clk);
    sleepMode <= 1'b1;
    wrSel(8'h55);
    pinDrive <= 4'hf;
    #1 waitRise(4, 20, n);
    cmpRange(n, 0, 6);
    final_report();
  end
endmodule
